// >>> core/temp_sensor_access_timeout_alert.sv
`timescale 1ns/1ns
module temp_sensor_access_timeout_alert
    import tsense_pkg::*;
#(
    parameter bit HAS_TIMEOUT = 1'b1,
    parameter int STUCK_COUNT = STUCK_CYCLES,
    parameter int CONV_COUNT = CONV_CYCLES
) (
    input wire logic ref_clk, // Core clock, 250 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic sclIn, // Bus clock pin level
    input wire logic sdaIn, // Bus data pin level
    output logic sdaOut, // Data drive value, always low
    output logic sdaOe_n, // Low while pulling data low
    input wire logic addr_select_bit2, // Address strap 2
    input wire logic addr_select_bit1, // Address strap 1
    input wire logic addr_select_bit0, // Address strap 0
    input wire logic slaveDrive, // Serial engine wants data pulled low
    input wire logic addrMatch, // Serial engine: address byte just matched
    input wire logic shutdown, // Shutdown mode from the configuration
    input wire logic [TEMP_W-1:0] convSample, // Converter output at end of conversion
    input wire logic [TEMP_W-1:0] limitHigh, // Over-limit set point
    input wire logic [TEMP_W-1:0] limitHyst, // Hysteresis set point
    input wire logic [2:0] faultCount, // Over-limit results needed, 1 to 6
    output logic [6:0] slaveAddr, // Address this device answers
    output logic [TEMP_W-1:0] tempValue, // Last completed conversion
    output logic convBusy, // A conversion is running
    output logic convDone, // One-cycle pulse when a result is stored
    output logic busActive, // Addressed transaction in progress
    output logic busReset, // One-cycle pulse: serial interface forced idle
    output logic alert // Overtemperature alert, active high
);
    // Refuse counts that the counters cannot serve
    if (STUCK_COUNT < 1) begin
        $error("STUCK_COUNT must be at least 1");
    end
    if (CONV_COUNT < 2) begin
        $error("CONV_COUNT must be at least 2");
    end

    localparam int SW = $clog2(STUCK_COUNT + 1);
    localparam int CW = $clog2(CONV_COUNT + 1);
    localparam logic [SW-1:0] STUCK_LAST = SW'(STUCK_COUNT);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_COUNT - 1);

    // Two's complement compare of a result against a set point
    function automatic logic isAbove(input logic [TEMP_W-1:0] a, input logic [TEMP_W-1:0] b);
        isAbove = $signed(a) > $signed(b);
    endfunction

    // Zero reads as one, anything past the queue depth as the depth
    function automatic logic [2:0] clampFaults(input logic [2:0] req);
        if (req == 3'h0) begin
            clampFaults = FAULT_RST;
        end else if (req > 3'(FAULT_MAX)) begin
            clampFaults = 3'(FAULT_MAX);
        end else begin
            clampFaults = req;
        end
    endfunction

    // Reset released through two flops so no register sees a ragged edge
    logic rstS1_r;
    logic rstS2_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstS1_r <= 1'h0;
            rstS2_r <= 1'h0;
        end else begin
            rstS1_r <= 1'h1;
            rstS2_r <= rstS1_r;
        end
    end
    wire rstN = rstS2_r;

    // Bus clock pin: two flops, a third so the high level must hold in two samples
    logic sclM_r;
    logic sclS_r;
    logic sclD_r;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            sclM_r <= 1'h1;
            sclS_r <= 1'h1;
            sclD_r <= 1'h1;
        end else begin
            sclM_r <= sclIn;
            sclS_r <= sclM_r;
            sclD_r <= sclS_r;
        end
    end

    // Bus data pin: idle level after reset so no false start follows it
    logic sdaM_r;
    logic sdaS_r;
    logic sdaD_r;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            sdaM_r <= 1'h1;
            sdaS_r <= 1'h1;
            sdaD_r <= 1'h1;
        end else begin
            sdaM_r <= sdaIn;
            sdaS_r <= sdaM_r;
            sdaD_r <= sdaS_r;
        end
    end

    wire sclHigh = sclS_r && sclD_r;
    wire startCond = sclHigh && sdaD_r && !sdaS_r;
    wire stopCond = sclHigh && !sdaD_r && sdaS_r;

    // Address straps are pins, so they pass two flops as well
    logic [2:0] strapM_r;
    logic [2:0] strap_r;
    wire [2:0] strapPins = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            strapM_r <= 3'h0;
            strap_r <= 3'h0;
        end else begin
            strapM_r <= strapPins;
            strap_r <= strapM_r;
        end
    end
    assign slaveAddr = {ADDR_FIXED, strap_r};

    // Bus-stuck timer
    logic [SW-1:0] stuck_r;
    wire stuckArmed = HAS_TIMEOUT && !shutdown;
    wire stuckHit = stuckArmed && !sdaS_r && (stuck_r == STUCK_LAST);
    wire stuckClear = sdaS_r || !stuckArmed || stuckHit;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) stuck_r <= '0;
        else if (stuckClear) stuck_r <= '0;
        else stuck_r <= stuck_r + SW'(1);
    end

    // One-cycle notice that the serial interface was forced idle
    logic busReset_r;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) busReset_r <= 1'h0;
        else busReset_r <= stuckHit;
    end

    // Data stays released after a timeout until the next start
    logic held_r;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) held_r <= 1'h0;
        else if (stuckHit) held_r <= 1'h1;
        else if (startCond) held_r <= 1'h0;
    end

    // Addressed-transaction tracking
    logic busActive_r;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) busActive_r <= 1'h0;
        else if (stuckHit || stopCond) busActive_r <= 1'h0;
        else if (addrMatch) busActive_r <= 1'h1;
    end
    assign busActive = busActive_r;
    assign busReset = busReset_r;
    assign sdaOut = 1'h0;
    assign sdaOe_n = !(slaveDrive && !held_r);

    // Conversion engine: an address match in the last cycle still aborts it
    logic [CW-1:0] conv_r;
    logic convDone_r;
    logic [TEMP_W-1:0] temp_r;
    wire convEnd = !busActive_r && !addrMatch && !shutdown && (conv_r == CONV_LAST);
    wire convClear = busActive_r || addrMatch || shutdown || convEnd;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) conv_r <= '0;
        else if (convClear) conv_r <= '0;
        else conv_r <= conv_r + CW'(1);
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) convDone_r <= 1'h0;
        else convDone_r <= convEnd;
    end

    // Only a finished conversion touches the stored result
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) temp_r <= '0;
        else if (convEnd) temp_r <= convSample;
    end
    assign tempValue = temp_r;
    assign convDone = convDone_r;
    assign convBusy = !busActive_r && !shutdown;

    // Consecutive fault filter
    logic [2:0] faults_r;
    logic alert_r;
    wire [2:0] needed = clampFaults(faultCount);
    wire overLimit = isAbove(convSample, limitHigh);
    wire belowHyst = isAbove(limitHyst, convSample);
    wire [2:0] faultsInc = faults_r + 3'h1;
    wire reachNeeded = faultsInc >= needed;
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            faults_r <= 3'h0;
        end else if (convEnd && !overLimit) begin
            faults_r <= 3'h0;
        end else if (convEnd && (faults_r < needed)) begin
            faults_r <= faultsInc;
        end
    end

    // Hysteresis release keeps the alert from chattering at the limit
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            alert_r <= 1'h0;
        end else if (convEnd && overLimit && reachNeeded) begin
            alert_r <= 1'h1;
        end else if (convEnd && !overLimit && belowHyst) begin
            alert_r <= 1'h0;
        end
    end
    assign alert = alert_r;
endmodule

// >>> core/tsense_pkg.sv
package tsense_pkg;
    // Base clock
    localparam int CLK_PERIOD_NS = 4;
    // Bus-stuck timeout window, milliseconds
    localparam int STUCK_MIN_MS = 75;
    localparam int STUCK_MAX_MS = 325;
    // Least time between transactions for a fresh result, milliseconds
    localparam int ACCESS_GAP_MS = 300;
    // Cycles per millisecond at the base clock
    localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
    // Timeout count: the least time, rounded down to whole cycles
    localparam int STUCK_CYCLES = STUCK_MIN_MS * CYC_PER_MS;
    // Conversion time default (fits below the recommended gap)
    localparam int CONV_MS = 100;
    localparam int CONV_CYCLES = CONV_MS * CYC_PER_MS;
    // Address and data layout
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam int TEMP_W = 9;
    localparam int FAULT_MAX = 6;
    localparam logic [2:0] FAULT_RST = 3'h1;
endpackage

// >>> test/tsense_properties.sv
`timescale 1ns/1ns
module tsense_properties
    import tsense_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic rst_n, // Reset, active low
    input wire logic sdaIn, // Data pin level
    input wire logic shutdown, // Shutdown mode
    input wire logic sdaOe_n, // Data drive enable, active low
    input wire logic convBusy, // Conversion running
    input wire logic convDone, // Result stored pulse
    input wire logic busActive, // Addressed transaction
    input wire logic busReset, // Stuck reset pulse
    input wire logic alert, // Overtemperature alert
    input wire logic [6:0] slaveAddr, // Answered address
    input wire logic [TEMP_W-1:0] tempValue, // Last result
    input wire logic [TEMP_W-1:0] limitHyst // Release point
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_addr_fixed: assert property (slaveAddr[6:3] == ADDR_FIXED) else $error("address");
    a_store_flag: assert property ($changed(tempValue) |-> convDone) else $error("store");
    a_hold_busy: assert property (busActive |=> $stable(tempValue)) else $error("hold");
    a_abort_conv: assert property (busActive |-> !convBusy) else $error("abort");
    a_store_idle: assert property ($changed(tempValue) |-> !$past(busActive)) else $error("idle");
    a_stuck_low: assert property (busReset |-> !$past(sdaIn, 8) && !$past(sdaIn, 40)) else $error("low");
    a_stuck_free: assert property (busReset |=> sdaOe_n) else $error("release");
    a_shut_off: assert property ($past(shutdown) |-> !busReset) else $error("shutdown");
    a_alert_off: assert property ($fell(alert) |-> $signed(tempValue) < $signed(limitHyst)) else $error("alert");
    c_done: cover property (convDone);
    c_reset: cover property (busReset);
    c_alert: cover property ($rose(alert));
    c_access: cover property ($rose(busActive));
endmodule

// >>> test/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
    output logic sclM, // Bus clock, stands high between frames
    output logic sdaM // Data drive, high means released to the pull-up
);
    initial begin
        sclM = 1'h1;
        sdaM = 1'h1;
    end
    // Data moves while the clock is low, except for the opening start and the closing stop
    task automatic xfer(input int n);
        sdaM = 1'h0;
        repeat (n) begin
            #24 sclM = 1'h0;
            sdaM = 1'h1;
            #24 sclM = 1'h1;
        end
        #24 sclM = 1'h0;
        sdaM = 1'h0;
        #24 sclM = 1'h1;
        #24 sdaM = 1'h1;
    endtask
endmodule

// >>> test/temp_sensor_access_timeout_alert_tb.sv
`timescale 1ns/1ns
module temp_sensor_access_timeout_alert_tb;
    import tsense_pkg::*;
    logic ref_clk = 1'h0, rst_n = 1'h0, slaveDrive = 1'h0, addrMatch = 1'h0, shutdown = 1'h0;
    logic [2:0] straps = 3'h0, faultCount = 3'h1;
    logic [TEMP_W-1:0] convSample = 9'h032, limitHigh = 9'h0FC, limitHyst = 9'h0F0, tempValue;
    logic sdaOut, sdaOe_n, convBusy, convDone, busActive, busReset, alert, sclM, sdaM;
    logic [6:0] slaveAddr;
    int miscompares = 0, samples_checked = 0;
    logic sdaOeNt_n, busResetNt;
    wire sda = sdaM & (sdaOe_n | sdaOut);
    wire sdaNt = sdaM & sdaOeNt_n;
    initial forever #2 ref_clk = ~ref_clk;
    i2c_master_model u_i2c_master_model (.sclM(sclM), .sdaM(sdaM));
    temp_sensor_access_timeout_alert #(.STUCK_COUNT(50), .CONV_COUNT(40)) u_temp_sensor_access_timeout_alert (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclM), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
        .addr_select_bit2(straps[2]), .addr_select_bit1(straps[1]), .addr_select_bit0(straps[0]),
        .slaveDrive(slaveDrive), .addrMatch(addrMatch), .shutdown(shutdown), .convSample(convSample),
        .limitHigh(limitHigh), .limitHyst(limitHyst), .faultCount(faultCount), .slaveAddr(slaveAddr),
        .tempValue(tempValue), .convBusy(convBusy), .convDone(convDone), .busActive(busActive),
        .busReset(busReset), .alert(alert));
    // Build variant without the bus-stuck timeout
    temp_sensor_access_timeout_alert #(.HAS_TIMEOUT(1'h0), .STUCK_COUNT(50), .CONV_COUNT(40))
        u_temp_sensor_access_timeout_alert_nt (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(sclM), .sdaIn(sdaNt), .sdaOut(), .sdaOe_n(sdaOeNt_n),
        .addr_select_bit2(straps[2]), .addr_select_bit1(straps[1]), .addr_select_bit0(straps[0]),
        .slaveDrive(slaveDrive), .addrMatch(addrMatch), .shutdown(shutdown), .convSample(convSample),
        .limitHigh(limitHigh), .limitHyst(limitHyst), .faultCount(faultCount), .slaveAddr(),
        .tempValue(), .convBusy(), .convDone(), .busActive(), .busReset(busResetNt), .alert());
    function automatic bit bad(input bit c);
        samples_checked++;
        return c;
    endfunction
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic err(input string m);
        miscompares++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic waitDone();
        int i;
        for (i = 0; i < 300 && convDone !== 1'h1; i++) cyc(1);
        if (bad(i == 300)) begin
            err("no result");
            summarize();
        end
        cyc(1);
    endtask
    task automatic access();
        fork
            u_i2c_master_model.xfer(9);
            begin
                cyc(4);
                addrMatch = 1'h1;
                cyc(1);
                addrMatch = 1'h0;
                cyc(2);
                if (bad(busActive !== 1'h1 || convBusy !== 1'h0)) err("abort");
            end
        join
        cyc(6);
        if (bad(busActive !== 1'h0)) err("stop");
    endtask
    task automatic res(input logic [TEMP_W-1:0] v, input int n, input logic a);
        convSample = v;
        repeat (n) waitDone();
        if (bad(alert !== a)) err("alert");
    endtask
    task automatic tAbort();
        waitDone();
        if (bad(tempValue !== 9'h032)) err("result");
        convSample = 9'h0FA;
        // Gaps far below one conversion, so no result may land
        repeat (3) begin
            access();
            cyc(14);
        end
        if (bad(tempValue !== 9'h032)) err("kept");
        waitDone();
        if (bad(tempValue !== 9'h0FA)) err("restart");
        $display("abort done");
    endtask
    task automatic tStuck();
        int i;
        int hits;
        slaveDrive = 1'h1;
        hits = 0;
        for (i = 0; i < 100 && busReset !== 1'h1; i++) begin
            cyc(1);
            hits += (busResetNt === 1'h1);
        end
        cyc(1);
        if (bad(i == 100 || sdaOe_n !== 1'h1)) err("stuck");
        if (bad(sdaOut !== 1'h0)) err("drive");
        if (bad(hits != 0 || busResetNt !== 1'h0 || sdaOeNt_n !== 1'h0)) err("variant");
        slaveDrive = 1'h0;
        u_i2c_master_model.xfer(1);
        shutdown = 1'h1;
        slaveDrive = 1'h1;
        hits = 0;
        repeat (100) begin
            cyc(1);
            hits += (busReset === 1'h1);
        end
        if (bad(hits != 0 || sdaOe_n !== 1'h0)) err("shutdown");
        slaveDrive = 1'h0;
        shutdown = 1'h0;
        $display("stuck done");
    endtask
    initial begin
        cyc(6);
        rst_n = 1'h1;
        straps = 3'h5;
        cyc(4);
        if (bad(slaveAddr !== {ADDR_FIXED, 3'h5})) err("address");
        tAbort();
        faultCount = 3'h3;
        res(9'h0FD, 2, 1'h0);
        res(9'h032, 1, 1'h0);
        res(9'h0FD, 2, 1'h0);
        res(9'h0FD, 1, 1'h1);
        res(9'h032, 1, 1'h0);
        $display("alert done");
        tStuck();
        summarize();
    end
endmodule
bind temp_sensor_access_timeout_alert tsense_properties u_tsense_properties (.ref_clk, .rst_n, .sdaIn, .shutdown,
    .sdaOe_n, .convBusy, .convDone, .busActive, .busReset, .alert, .slaveAddr, .tempValue, .limitHyst);
